// [kvs_pkg.sv]
// Purpose: Shared constants and types for kernel address decode
// Assumes: 64-bit virtual, 32-bit physical addresses
// Notes:   Register map, field layout and decode encodings
package kvs_pkg;
  // ***************************************************
  // Register map and fields
  // ***************************************************
  localparam logic [7:0]  ADR_CTRL    = 8'h00;
  localparam logic [7:0]  ADR_TAG     = 8'h04;
  localparam logic [7:0]  ADR_STAT    = 8'h08;
  localparam logic [7:0]  ADR_ERRCNT  = 8'h0c;
  localparam int          CTRL_KX     = 0;
  localparam int          CTRL_ERL    = 1;
  localparam int          CTRL_EXL    = 2;
  localparam int          CTRL_PRIV   = 3;
  localparam int          CTRL_K0     = 5;
  localparam logic [7:0]  CTRL_RST    = 8'h00;
  localparam logic [7:0]  TAG_RST     = 8'h00;
  localparam logic [15:0] ERRCNT_RST  = 16'h0000;
  localparam logic [15:0] ERRCNT_MAX  = 16'hffff;
  // ***************************************************
  // Decode constants
  // ***************************************************
  localparam logic [1:0]  PRIV_KERNEL = 2'h0;
  localparam logic [2:0]  SEG_CDIRECT = 3'h4;
  localparam logic [2:0]  SEG_UDIRECT = 3'h5;
  localparam logic [2:0]  SEG_SUPER   = 3'h6;
  localparam logic [2:0]  SEG_TOP     = 3'h7;
  localparam logic [31:0] BASE_CACHED = 32'h8000_0000;
  localparam logic [31:0] BASE_UNCACH = 32'ha000_0000;
  localparam logic [1:0]  W_USER      = 2'h0;
  localparam logic [1:0]  W_SUPER     = 2'h1;
  localparam logic [1:0]  W_PHYS      = 2'h2;
  localparam logic [1:0]  W_KERNEL    = 2'h3;
  localparam logic [2:0]  CCA_UNCACH  = 3'h2;
  localparam logic [39:0] WKERN_LAST  = 40'hff_7fff_ffff;

  typedef enum logic [3:0] {
    RG_NONE = 4'h0, RG_USER = 4'h1, RG_USER_DIRECT = 4'h2,
    RG_CACHED_DIRECT = 4'h3, RG_UNCACHED_DIRECT = 4'h4,
    RG_SUPER = 4'h5, RG_MAPPED_TOP = 4'h6, RG_WIDE_USER = 4'h7,
    RG_WIDE_SUPER = 4'h8, RG_WIDE_PHYS = 4'h9, RG_WIDE_KERNEL = 4'ha,
    RG_COMPAT_CACHED = 4'hb, RG_COMPAT_UNCACHED = 4'hc,
    RG_COMPAT_SUPER = 4'hd, RG_COMPAT_TOP = 4'he, RG_ADDR_ERR = 4'hf
  } kvs_region_e;

  typedef enum logic [1:0] {
    CS_UNCACHED = 2'h0, CS_CACHED = 2'h1, CS_TLB = 2'h2, CS_CFG = 2'h3
  } kvs_cache_e;

  typedef struct packed {
    kvs_region_e region;
    logic        mapped;
    logic        tag_en;
    logic        err;
    kvs_cache_e  cache;
    logic [31:0] paddr;
  } kvs_dec_s;

  typedef struct packed {
    logic        kernel;
    kvs_dec_s    dec;
    logic [7:0]  tag;
    logic [63:0] vaddr;
  } kvs_rsp_s;
endpackage : kvs_pkg

// [kvs_seg32.sv]
// Purpose: 32-bit kernel segment decode
// Assumes: Address already in kernel mode
// Notes:   Purely combinational
`timescale 1ns/100ps
module kvs_seg32 (
  input  logic             [31:0] vaddr_i,
  input  logic                    erl_i,
  output kvs_pkg::kvs_dec_s       dec_o
);
  import kvs_pkg::*;

  always_comb begin
    dec_o        = '0;
    dec_o.region = RG_NONE;
    dec_o.cache  = CS_TLB;
    dec_o.paddr  = vaddr_i;
    if (!vaddr_i[31]) begin
      if (erl_i) begin
        dec_o.region = RG_USER_DIRECT;
        dec_o.cache  = CS_UNCACHED;
      end else begin
        dec_o.region = RG_USER;
        dec_o.mapped = 1'b1;
        dec_o.tag_en = 1'b1;
      end
    end else begin
      case (vaddr_i[31:29])
        SEG_CDIRECT: begin
          dec_o.region = RG_CACHED_DIRECT;
          dec_o.paddr  = vaddr_i - BASE_CACHED;
          dec_o.cache  = CS_CFG;
        end
        SEG_UDIRECT: begin
          dec_o.region = RG_UNCACHED_DIRECT;
          dec_o.paddr  = vaddr_i - BASE_UNCACH;
          dec_o.cache  = CS_UNCACHED;
        end
        SEG_SUPER: begin
          dec_o.region = RG_SUPER;
          dec_o.mapped = 1'b1;
          dec_o.tag_en = 1'b1;
        end
        SEG_TOP: begin
          dec_o.region = RG_MAPPED_TOP;
          dec_o.mapped = 1'b1;
          dec_o.tag_en = 1'b1;
        end
        default: dec_o.region = RG_NONE;
      endcase
    end
  end
endmodule : kvs_seg32

// [kvs_seg64.sv]
// Purpose: 64-bit kernel segment decode
// Assumes: Address already in kernel mode
// Notes:   Purely combinational
`timescale 1ns/100ps
module kvs_seg64 (
  input  logic             [63:0] vaddr_i,
  input  logic                    erl_i,
  output kvs_pkg::kvs_dec_s       dec_o
);
  import kvs_pkg::*;

  logic beyond_tb;
  logic compat;

  assign beyond_tb = |vaddr_i[61:40];
  assign compat    = &vaddr_i[61:31];

  always_comb begin
    dec_o        = '0;
    dec_o.region = RG_ADDR_ERR;
    dec_o.cache  = CS_TLB;
    dec_o.paddr  = vaddr_i[31:0];
    case (vaddr_i[63:62])
      W_USER: begin
        if (erl_i && ~|vaddr_i[61:31]) begin
          dec_o.region = RG_USER_DIRECT;
          dec_o.cache  = CS_UNCACHED;
        end else if (beyond_tb) begin
          dec_o.err    = 1'b1;
        end else begin
          dec_o.region = RG_WIDE_USER;
          dec_o.mapped = 1'b1;
          dec_o.tag_en = 1'b1;
        end
      end
      W_SUPER: begin
        if (beyond_tb) begin
          dec_o.err    = 1'b1;
        end else begin
          dec_o.region = RG_WIDE_SUPER;
          dec_o.mapped = 1'b1;
          dec_o.tag_en = 1'b1;
        end
      end
      W_PHYS: begin
        if (|vaddr_i[58:32]) begin
          dec_o.err    = 1'b1;
        end else begin
          dec_o.region = RG_WIDE_PHYS;
          dec_o.cache  = (vaddr_i[61:59] == CCA_UNCACH) ? CS_UNCACHED : CS_CACHED;
        end
      end
      W_KERNEL: begin
        if (compat) begin
          case (vaddr_i[30:29])
            2'h0: begin
              dec_o.region = RG_COMPAT_CACHED;
              dec_o.paddr  = vaddr_i[31:0] - BASE_CACHED;
              dec_o.cache  = CS_CFG;
            end
            2'h1: begin
              dec_o.region = RG_COMPAT_UNCACHED;
              dec_o.paddr  = vaddr_i[31:0] - BASE_UNCACH;
              dec_o.cache  = CS_UNCACHED;
            end
            default: begin
              dec_o.region = vaddr_i[29] ? RG_COMPAT_TOP : RG_COMPAT_SUPER;
              dec_o.mapped = 1'b1;
              dec_o.tag_en = 1'b1;
            end
          endcase
        end else if (beyond_tb || vaddr_i[39:0] > WKERN_LAST) begin
          dec_o.err    = 1'b1;
        end else begin
          dec_o.region = RG_WIDE_KERNEL;
          dec_o.mapped = 1'b1;
          dec_o.tag_en = 1'b1;
        end
      end
      default: dec_o.err = 1'b1;
    endcase
  end
endmodule : kvs_seg64

// [kvs_decoder.sv]
// Purpose: Kernel-mode virtual address segment decoder
// Assumes: Classic Wishbone slave, one request per cycle
// Notes:   Response one cycle after each request

`timescale 1ns/100ps

module kvs_decoder (
  input  logic                    clk_i,
  input  logic                    rst_i,
  input  logic                    wb_cyc_i,
  input  logic                    wb_stb_i,
  input  logic                    wb_we_i,
  input  logic             [7:0]  wb_adr_i,
  input  logic             [3:0]  wb_sel_i,
  input  logic             [31:0] wb_dat_i,
  output logic             [31:0] wb_dat_o,
  output logic                    wb_ack_o,
  input  logic                    req_valid_i,
  input  logic             [63:0] req_vaddr_i,
  input  logic                    tlb_cbit_i,
  output logic                    rsp_valid_o,
  output kvs_pkg::kvs_rsp_s       rsp_o,
  output logic                    rsp_cached_o
);
  import kvs_pkg::*;

  // ***************************************************
  // State
  // ***************************************************
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  tag;
    logic        ack;
    logic [31:0] rdata;
    logic        rsp_valid;
    kvs_rsp_s    rsp;
    logic [15:0] errcnt;
  } kvs_state_s;

  kvs_state_s  st_ff;
  kvs_state_s  nxt_st;
  kvs_dec_s    dec32;
  kvs_dec_s    dec64;
  kvs_dec_s    dec_sel;
  logic [63:0] ext_vaddr;
  logic        kx;
  logic        error_level_bit;
  logic        exception_level_bit;
  logic [1:0]  priv;
  logic [2:0]  k0;
  logic        kmode;
  logic        wb_req;
  logic        err_evt;

  assign kx    = st_ff.ctrl[CTRL_KX];
  assign error_level_bit   = st_ff.ctrl[CTRL_ERL];
  assign exception_level_bit   = st_ff.ctrl[CTRL_EXL];
  assign priv  = st_ff.ctrl[CTRL_PRIV +: 2];
  assign k0    = st_ff.ctrl[CTRL_K0 +: 3];
  assign kmode = (priv == PRIV_KERNEL) | exception_level_bit | error_level_bit;
  assign wb_req = wb_cyc_i & wb_stb_i;

  // ***************************************************
  // Segment decoders
  // ***************************************************
  assign ext_vaddr = kx ? req_vaddr_i : {{32{req_vaddr_i[31]}}, req_vaddr_i[31:0]};

  kvs_seg32 u_seg32 (
    .vaddr_i (ext_vaddr[31:0]),
    .erl_i   (error_level_bit),
    .dec_o   (dec32)
  );

  kvs_seg64 u_seg64 (
    .vaddr_i (ext_vaddr),
    .erl_i   (error_level_bit),
    .dec_o   (dec64)
  );

  always_comb begin
    dec_sel = kx ? dec64 : dec32;
    if (dec_sel.cache == CS_CFG) begin
      dec_sel.cache = (k0 == CCA_UNCACH) ? CS_UNCACHED : CS_CACHED;
    end
  end

  assign err_evt = req_valid_i & kmode & dec_sel.err;

  // ***************************************************
  // Next state
  // ***************************************************
  always_comb begin
    nxt_st           = st_ff;
    nxt_st.rsp_valid = req_valid_i;
    if (req_valid_i) begin
      nxt_st.rsp.kernel = kmode;
      nxt_st.rsp.tag    = st_ff.tag;
      nxt_st.rsp.vaddr  = ext_vaddr;
      if (kmode) begin
        nxt_st.rsp.dec = dec_sel;
      end else begin
        nxt_st.rsp.dec        = '0;
        nxt_st.rsp.dec.region = RG_NONE;
        nxt_st.rsp.dec.cache  = CS_UNCACHED;
      end
    end
    if (err_evt && st_ff.errcnt != ERRCNT_MAX) begin
      nxt_st.errcnt = st_ff.errcnt + 16'h0001;
    end
    // Bus: answer one cycle after request, drop next
    nxt_st.ack   = wb_req & ~st_ff.ack;
    nxt_st.rdata = 32'h0000_0000;
    if (wb_req && !st_ff.ack && !wb_we_i) begin
      case (wb_adr_i)
        ADR_CTRL:   nxt_st.rdata = {24'h00_0000, st_ff.ctrl};
        ADR_TAG:    nxt_st.rdata = {24'h00_0000, st_ff.tag};
        ADR_STAT:   nxt_st.rdata = {22'h00_0000, st_ff.rsp.dec.cache, st_ff.rsp.dec.err,
                                    st_ff.rsp.dec.mapped, st_ff.rsp.dec.tag_en,
                                    st_ff.rsp.kernel, st_ff.rsp.dec.region};
        ADR_ERRCNT: nxt_st.rdata = {16'h0000, st_ff.errcnt};
        default:    nxt_st.rdata = 32'h0000_0000;
      endcase
    end
    // Writes land on the edge where ack is sampled
    if (wb_req && st_ff.ack && wb_we_i) begin
      case (wb_adr_i)
        ADR_CTRL: begin
          if (wb_sel_i[0]) begin
            nxt_st.ctrl = wb_dat_i[7:0];
          end
        end
        ADR_TAG: begin
          if (wb_sel_i[0]) begin
            nxt_st.tag = wb_dat_i[7:0];
          end
        end
        ADR_ERRCNT: begin
          // Clear wins, but a new error in the same cycle leaves a count of one
          if (|wb_sel_i) begin
            nxt_st.errcnt = err_evt ? 16'h0001 : ERRCNT_RST;
          end
        end
        default: nxt_st.ctrl = st_ff.ctrl;
      endcase
    end
    if (rst_i) begin
      nxt_st        = '0;
      nxt_st.ctrl   = CTRL_RST;
      nxt_st.tag    = TAG_RST;
      nxt_st.errcnt = ERRCNT_RST;
    end
  end

  always_ff @(posedge clk_i) begin
    st_ff <= nxt_st;
  end

  // ***************************************************
  // Outputs
  // ***************************************************
  assign wb_ack_o    = st_ff.ack;
  assign wb_dat_o    = st_ff.rdata;
  assign rsp_valid_o = st_ff.rsp_valid;
  assign rsp_o       = st_ff.rsp;
  assign rsp_cached_o = (st_ff.rsp.dec.cache == CS_TLB) ? tlb_cbit_i :
                        (st_ff.rsp.dec.cache == CS_CACHED);

  // ***************************************************
  // Checks
  // ***************************************************
  logic req_k;
  assign req_k = req_valid_i & kmode;

  AST_ERL_LOW_DIRECT: assert property (
    @(posedge clk_i) disable iff (rst_i)
    req_k && error_level_bit && !kx && !req_vaddr_i[31]
    |=> rsp_valid_o && rsp_o.dec.region == RG_USER_DIRECT && !rsp_o.dec.mapped
        && !rsp_cached_o && rsp_o.dec.paddr == $past(req_vaddr_i[31:0])
  ) else $error("error level low space not direct");

  AST_CACHED_DIRECT_PA: assert property (
    @(posedge clk_i) disable iff (rst_i)
    req_k && !kx && req_vaddr_i[31:29] == 3'h4
    |=> !rsp_o.dec.mapped && rsp_o.dec.paddr == rsp_o.vaddr[31:0] - 32'h8000_0000
  ) else $error("cached direct physical address wrong");

  AST_K0_CACHE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    req_k && (dec_sel.region == RG_CACHED_DIRECT || dec_sel.region == RG_COMPAT_CACHED)
    |=> rsp_cached_o == ($past(k0) != 3'h2)
  ) else $error("cached direct ignores config field");

  AST_UNCACHED_DIRECT: assert property (
    @(posedge clk_i) disable iff (rst_i)
    req_k && !kx && req_vaddr_i[31:29] == 3'h5
    |=> !rsp_cached_o && !rsp_o.dec.mapped
        && rsp_o.dec.paddr == rsp_o.vaddr[31:0] - 32'ha000_0000
  ) else $error("uncached direct region wrong");

  AST_MAPPED_TLB: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rsp_valid_o && rsp_o.dec.mapped |-> rsp_cached_o == tlb_cbit_i && rsp_o.dec.tag_en
  ) else $error("mapped access cache not from entry");

  AST_PHYS_ERR: assert property (
    @(posedge clk_i) disable iff (rst_i)
    req_k && kx && req_vaddr_i[63:62] == 2'h2 && |req_vaddr_i[58:32]
    |=> rsp_o.dec.err ##1 (st_ff.errcnt != 16'h0000)
  ) else $error("physical window error missed");

  AST_PHYS_CACHE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    req_k && kx && req_vaddr_i[63:62] == 2'h2 && !(|req_vaddr_i[58:32])
    |=> rsp_cached_o == ($past(req_vaddr_i[61:59]) != 3'h2)
        && rsp_o.dec.paddr == $past(req_vaddr_i[31:0])
  ) else $error("physical window cacheability wrong");

  AST_COMPAT_SEL: assert property (
    @(posedge clk_i) disable iff (rst_i)
    req_k && kx && &req_vaddr_i[63:31]
    |=> rsp_o.dec.region == kvs_region_e'(4'hb + {2'h0, $past(req_vaddr_i[30:29])})
  ) else $error("compat space selection wrong");

  AST_WIDE_LIMIT: assert property (
    @(posedge clk_i) disable iff (rst_i)
    req_k && kx && !req_vaddr_i[63] && |req_vaddr_i[61:40]
    |=> rsp_o.dec.err && !rsp_o.dec.mapped
  ) else $error("wide address past limit accepted");

  AST_NOT_KERNEL: assert property (
    @(posedge clk_i) disable iff (rst_i)
    req_valid_i && !kmode
    |=> rsp_valid_o && !rsp_o.kernel && rsp_o.dec.region == RG_NONE && !rsp_o.dec.err
  ) else $error("decode applied outside kernel mode");

  AST_WB_ACK: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o
  ) else $error("bus answer timing wrong");
endmodule : kvs_decoder

// [kvs_tlb_model.sv]
// Purpose: Behavioural TLB lookup beside the kernel address decoder
// Assumes: Page cache attribute bit follows virtual address bit 12
// Notes:   Outside a response the bit toggles every cycle
`timescale 1ns/100ps
module kvs_tlb_model (
  input  wire logic        clk_i,
  input  wire logic        rsp_valid_i,
  input  wire logic [63:0] vaddr_i,
  output logic             tlb_cbit_o
);
  logic idle_ff = 1'b0;

  // ***************************************************
  // Lookup result
  // ***************************************************
  always_ff @(posedge clk_i) begin
    idle_ff <= ~idle_ff;
  end

  // No stale value between lookups
  assign tlb_cbit_o = rsp_valid_i ? vaddr_i[12] : idle_ff;
endmodule : kvs_tlb_model

// [kvs_tb.sv]
// Purpose: Self-checking bench for the kernel address decoder
// Assumes: Classic Wishbone register access, one-cycle decode latency
// Notes:   Expected decodes worked out per region from the address bits
`timescale 1ns/100ps
module tb;
  import kvs_pkg::*;
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              wb_cyc_i = 1'b0;
  logic              wb_stb_i = 1'b0;
  logic              wb_we_i = 1'b0;
  logic [7:0]        wb_adr_i = 8'h00;
  logic [3:0]        wb_sel_i = 4'h0;
  logic [31:0]       wb_dat_i = 32'h0;
  logic [31:0]       wb_dat_o;
  logic              wb_ack_o;
  logic              req_valid_i = 1'b0;
  logic [63:0]       req_vaddr_i = 64'h0;
  logic              tlb_cbit_i;
  logic              rsp_valid_o;
  kvs_rsp_s          rsp_o;
  logic              rsp_cached_o;
  int                fails = 0;
  int                samples_checked = 0;
  int                cyc_cnt = 0;

  always #2 clk_i = ~clk_i;

  kvs_decoder dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .req_valid_i(req_valid_i),
    .req_vaddr_i(req_vaddr_i), .tlb_cbit_i(tlb_cbit_i), .rsp_valid_o(rsp_valid_o),
    .rsp_o(rsp_o), .rsp_cached_o(rsp_cached_o)
  );

  kvs_tlb_model tlb (
    .clk_i(clk_i), .rsp_valid_i(rsp_valid_o), .vaddr_i(rsp_o.vaddr), .tlb_cbit_o(tlb_cbit_i)
  );

  // ***************************************************
  // Checking and closing
  // ***************************************************
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt > 5000) begin
      fails++;
      print_verdict();
    end
  end

  // ***************************************************
  // Wishbone access
  // ***************************************************
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] d,
                         output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    if (n >= 20) chk("wb_ack", 1, 0);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
  endtask : wb_xfer

  task automatic wb_write(input logic [7:0] adr, input logic [31:0] d);
    logic [31:0] q;
    wb_xfer(1'b1, adr, d, q);
  endtask : wb_write

  task automatic wb_read(input logic [7:0] adr, input logic [31:0] e);
    logic [31:0] q;
    wb_xfer(1'b0, adr, 32'h0, q);
    chk("wb_dat", e, q);
  endtask : wb_read

  // ***************************************************
  // Decode request; mec is mapped, err, cached
  // ***************************************************
  task automatic dec(input logic [63:0] a, input kvs_region_e rg, input logic [2:0] mec,
                     input logic [31:0] pa, input logic full);
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_vaddr_i <= a;
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    #1;
    chk("rsp_valid", 1, rsp_valid_o);
    chk("region", rg, rsp_o.dec.region);
    chk("kernel", rg != RG_NONE, rsp_o.kernel);
    chk("err", mec[1], rsp_o.dec.err);
    if (full) begin
      chk("mapped", mec[2], rsp_o.dec.mapped);
      chk("tag_en", mec[2], rsp_o.dec.tag_en);
      chk("cached", mec[0], rsp_cached_o);
      if (!mec[2]) chk("paddr", pa, rsp_o.dec.paddr);
    end
  endtask : dec

  // ***************************************************
  // Main sequence
  // ***************************************************
  initial begin
    logic [63:0] a;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_read(ADR_CTRL, 32'h0);
    wb_read(ADR_ERRCNT, 32'h0);
    wb_write(ADR_TAG, 32'h5a);
    wb_write(ADR_CTRL, 32'h60);
    wb_read(ADR_CTRL, 32'h60);
    wb_read(ADR_TAG, 32'h5a);
    wb_read(8'h10, 32'h0);
    dec(64'h0000_1000, RG_USER, 3'b101, 32'h0, 1);
    chk("tag", 8'h5a, rsp_o.tag);
    dec(64'h8000_1234, RG_CACHED_DIRECT, 3'b001, 32'h0000_1234, 1);
    @(posedge clk_i);
    #1 chk("rsp_valid_drop", 0, rsp_valid_o);
    dec(64'hbfff_fff0, RG_UNCACHED_DIRECT, 3'b000, 32'h1fff_fff0, 1);
    dec(64'hc000_0000, RG_SUPER, 3'b100, 32'h0, 1);
    dec(64'he000_1000, RG_MAPPED_TOP, 3'b101, 32'h0, 1);
    dec(64'h1234_5678_8000_1234, RG_CACHED_DIRECT, 3'b001, 32'h0000_1234, 1);
    chk("vaddr", 64'hffff_ffff_8000_1234, rsp_o.vaddr);
    wb_write(ADR_CTRL, 32'h40);
    dec(64'h8000_0000, RG_CACHED_DIRECT, 3'b000, 32'h0, 1);
    wb_write(ADR_CTRL, 32'h62);
    dec(64'h0000_1000, RG_USER_DIRECT, 3'b000, 32'h0000_1000, 1);
    wb_write(ADR_CTRL, 32'h70);
    dec(64'hc000_0000, RG_NONE, 3'b000, 32'h0, 0);
    wb_write(ADR_CTRL, 32'h74);
    dec(64'hc000_0000, RG_SUPER, 3'b100, 32'h0, 1);
    wb_write(ADR_CTRL, 32'h61);
    dec(64'h0000_00ff_ffff_f000, RG_WIDE_USER, 3'b101, 32'h0, 1);
    dec(64'h0000_0100_0000_0000, RG_ADDR_ERR, 3'b010, 32'h0, 0);
    dec(64'h4000_0000_0000_1000, RG_WIDE_SUPER, 3'b101, 32'h0, 1);
    dec(64'h4000_0100_0000_0000, RG_ADDR_ERR, 3'b010, 32'h0, 0);
    for (int k = 0; k < 8; k++) begin
      a = {2'b10, 3'(k), 27'h0, 32'h1234_5000};
      dec(a, RG_WIDE_PHYS, {2'b00, k != 2}, 32'h1234_5000, 1);
    end
    wb_write(ADR_ERRCNT, 32'h0);
    dec(64'h8000_0001_0000_0000, RG_ADDR_ERR, 3'b010, 32'h0, 0);
    wb_read(ADR_ERRCNT, 32'h1);
    dec(64'hc000_00ff_7fff_f000, RG_WIDE_KERNEL, 3'b101, 32'h0, 1);
    dec(64'hc000_00ff_8000_0000, RG_ADDR_ERR, 3'b010, 32'h0, 0);
    dec(64'hffff_ffff_8000_0010, RG_COMPAT_CACHED, 3'b001, 32'h0000_0010, 1);
    dec(64'hffff_ffff_a000_0010, RG_COMPAT_UNCACHED, 3'b000, 32'h0000_0010, 1);
    dec(64'hffff_ffff_c000_1000, RG_COMPAT_SUPER, 3'b101, 32'h0, 1);
    dec(64'hffff_ffff_e000_0000, RG_COMPAT_TOP, 3'b100, 32'h0, 1);
    wb_read(ADR_STAT, 32'h0000_027e);
    print_verdict();
  end
endmodule : tb
